// ==== src/cursor_position_match_defs.svh ====
// Offsets, field positions, reset values and widths for the cursor position match block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef CURSOR_POSITION_MATCH_DEFS_SVH
`define CURSOR_POSITION_MATCH_DEFS_SVH

// Counter widths and decoded row end
`define COL_WIDTH 7
`define ROW_WIDTH 5
`define ROW_LAST_COUNT 26

// Register bus geometry
`define AXI_ADDR_WIDTH 4
`define AXI_DATA_WIDTH 32

// Register byte offsets
`define POSITION_OFS 4'h0
`define STATUS_OFS 4'h4
`define CONTROL_OFS 4'h8

// Position register fields
`define POS_COL_LSB 0
`define POS_ROW_LSB 8

// Status register fields
`define STAT_CMATCH_LSB 0
`define STAT_RMATCH_LSB 8
`define STAT_TOP_BIT 16
`define STAT_BOTTOM_BIT 17
`define STAT_RHIT_BIT 18
`define STAT_CHIT_N_BIT 19

// Control register fields and reset value
`define CTRL_KEY_EN_BIT 0
`define CTRL_RESET 1'h1

`endif

// ==== src/cursor_position_match_pkg.sv ====
// Types shared by the cursor position match block.
// Assumes the defs header sits in the include path.
`include "cursor_position_match_defs.svh"

package cursor_position_match_pkg;

   // Bus answer codes
   typedef enum logic [1:0] {
      RESP_OKAY = 2'h0,
      RESP_SLVERR = 2'h2
   } axi_resp_t;

   // Direction in which a cursor step moves the row counter
   typedef enum logic [1:0] {
      DIR_DOWN = 2'h1,
      DIR_UP = 2'h2
   } step_dir_t;

endpackage : cursor_position_match_pkg

// ==== src/cursor_position_match.sv ====
// Cursor position match logic: column and row match counters, column preset path,
// row up/down counter with control and end decode, plus an AXI4-Lite register slave.
// Assumes all strobes and phase pulses are one clk cycle wide and synchronous to clk.
//
// Overview of operation
// R01: Column match load stores complement of cursor column each sweep.
// R02: That load also sets the extra top bit, so column hit reads high.
// R03: Refresh side delivers column steps during unblanked sweep, 100 ns every 700 ns; the bench model gives one-clk steps every other clk.
// R04: Column steps count only while refresh pass enable is one.
// R05: Each step increments; rolling past all ones drives column hit low.
// R06: In skip refresh the load still happens but steps are inhibited; value held.
// R07: Restore saved cursor routes held column match value toward column counter.
// R08: Host column load drives inverted host column bits onto preset lines.
// R09: Restore saved cursor with phase four gates match count onto preset lines.
// R10: Preset lines are active low, carrying complement of the loaded column.
// R11: Cursor row lives in a 5-bit up/down counter, exported to other logic.
// R12: Row end decode flags row zero and row 26.
// R13: Row next increments, row previous decrements, once per cursor step.
// R14: Host row next with host step pulse makes an incrementing step.
// R15: Keyboard row moves act only with sequencer slot four.
// R16: Keyboard down ignored at row 26, keyboard up ignored at row zero.
// R17: Host row load drives row counter load output low.
// R18: Line delete roll or restore passes phase four to row load output.
// R19: Row match input: low four row bits via inverters, top bit from inverted output.
// R20: Row match load stores that complemented row at field start.
// R21: Row match counter advances on trailing edge of each row match gate.
// R22: Row match outputs all high while refreshed line equals cursor row.
// R23: Cursor column is a 7-bit value; its complement moves through the paths.
// R24: Column wrap forward steps row down, column wrap back steps row up.
// R25: Everything runs on clk with pulses used as one-cycle enables.
`timescale 1ns/100ps
`include "cursor_position_match_defs.svh"

module cursor_position_match
   import cursor_position_match_pkg::*;
#(
   parameter int COL_W = `COL_WIDTH,
   parameter int ROW_W = `ROW_WIDTH,
   parameter int ROW_LAST = `ROW_LAST_COUNT
) (
   input wire logic clk,
   input wire logic rst_b,
   // Column side
   input wire logic [COL_W-1:0] cursor_column,
   input wire logic column_match_load,
   input wire logic column_match_step,
   input wire logic refresh_pass_en,
   input wire logic restore_saved_cursor,
   input wire logic phase_four_pulse,
   input wire logic phase_three_pulse,
   input wire logic host_column_load,
   input wire logic [COL_W-1:0] host_column_bits,
   input wire logic column_wrap_forward,
   input wire logic column_wrap_back,
   // Row side
   input wire logic row_next,
   input wire logic row_previous,
   input wire logic host_row_next,
   input wire logic host_step_pulse,
   input wire logic key_row_up,
   input wire logic key_row_down_return,
   input wire logic sequencer_slot_four,
   input wire logic host_row_load,
   input wire logic [ROW_W-1:0] host_row_bits,
   input wire logic line_delete_restore,
   input wire logic row_match_load,
   input wire logic row_match_gate,
   // Outputs
   output logic column_hit_n,
   output logic [COL_W-1:0] column_preset_n,
   output logic column_preset_strobe,
   output logic [ROW_W-1:0] cursor_row,
   output logic row_at_top,
   output logic row_at_bottom,
   output logic row_counter_load_n,
   output logic cursor_step_pulse,
   output logic [ROW_W-1:0] row_match_count,
   output logic row_match_hit,
   // AXI4-Lite slave
   input wire logic [`AXI_ADDR_WIDTH-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [`AXI_DATA_WIDTH-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`AXI_ADDR_WIDTH-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [`AXI_DATA_WIDTH-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   localparam int CM_W = COL_W + 1;
   localparam logic [CM_W-1:0] CM_ONE = CM_W'(1);
   localparam logic [ROW_W-1:0] ROW_ONE = ROW_W'(1);
   localparam logic [ROW_W-1:0] ROW_END = ROW_W'(ROW_LAST);

   // Elaboration check on widths the fields and decode can hold
   if (COL_W < 1 || COL_W > 8 || ROW_W < 2 || ROW_W > 8 || ROW_LAST < 1 || ROW_LAST >= (1 << ROW_W)) begin : g_chk
      $error("cursor_position_match: unsupported width or row end");
   end

   // ---------------- State ----------------
   logic [CM_W-1:0] column_match_r, column_match_nxt;
   logic [COL_W-1:0] column_preset_n_r, column_preset_n_nxt;
   logic column_preset_strobe_r, column_preset_strobe_nxt;
   logic column_hit_n_r, column_hit_n_nxt;
   logic [ROW_W-1:0] cursor_row_r, cursor_row_nxt;
   logic row_at_top_r, row_at_top_nxt;
   logic row_at_bottom_r, row_at_bottom_nxt;
   logic row_counter_load_n_r, row_counter_load_n_nxt;
   logic cursor_step_pulse_r, cursor_step_pulse_nxt;
   logic [ROW_W-1:0] row_match_r, row_match_nxt;
   logic row_match_hit_r, row_match_hit_nxt;
   logic row_gate_prev_r;
   logic key_enable_r, key_enable_nxt;
   // Bus state
   logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
   logic [`AXI_ADDR_WIDTH-1:0] awaddr_r, awaddr_nxt;
   logic [`AXI_DATA_WIDTH-1:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt;
   axi_resp_t bresp_r, bresp_nxt;
   logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
   logic [`AXI_DATA_WIDTH-1:0] rdata_r, rdata_nxt;
   axi_resp_t rresp_r, rresp_nxt;

   // Decoded write effects on the cursor logic
   logic sw_col_wr, sw_row_wr;
   logic [`AXI_ADDR_WIDTH-1:0] wr_addr;
   logic [`AXI_DATA_WIDTH-1:0] wr_data;
   logic [3:0] wr_strb;
   logic do_write;

   // ---------------- Register bus ----------------
   // Address and data are taken in either order; response follows both
   always_comb begin
      aw_held_nxt = aw_held_r | (s_axi_awvalid & awready_r);
      w_held_nxt = w_held_r | (s_axi_wvalid & wready_r);
      awaddr_nxt = (s_axi_awvalid & awready_r) ? s_axi_awaddr : awaddr_r;
      wdata_nxt = (s_axi_wvalid & wready_r) ? s_axi_wdata : wdata_r;
      wstrb_nxt = (s_axi_wvalid & wready_r) ? s_axi_wstrb : wstrb_r;
      wr_addr = awaddr_nxt;
      wr_data = wdata_nxt;
      wr_strb = wstrb_nxt;
      do_write = aw_held_nxt & w_held_nxt;
      sw_col_wr = 1'h0;
      sw_row_wr = 1'h0;
      key_enable_nxt = key_enable_r;
      bresp_nxt = bresp_r;
      if (do_write) begin
         aw_held_nxt = 1'h0;
         w_held_nxt = 1'h0;
         bresp_nxt = RESP_OKAY;
         if (wr_addr == `POSITION_OFS) begin
            sw_col_wr = wr_strb[0];
            sw_row_wr = wr_strb[1];
         end else if (wr_addr == `CONTROL_OFS) begin
            if (wr_strb[0]) begin
               key_enable_nxt = wr_data[`CTRL_KEY_EN_BIT];
            end
         end else if (wr_addr != `STATUS_OFS) begin
            bresp_nxt = RESP_SLVERR;
         end
      end
      bvalid_nxt = do_write | (bvalid_r & ~s_axi_bready);
      awready_nxt = ~aw_held_nxt & ~bvalid_nxt;
      wready_nxt = ~w_held_nxt & ~bvalid_nxt;
   end

   // Read path: one outstanding read, data one cycle after the address is taken
   always_comb begin
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (s_axi_arvalid & arready_r) begin
         rdata_nxt = '0;
         rresp_nxt = RESP_OKAY;
         if (s_axi_araddr == `POSITION_OFS) begin
            rdata_nxt[`POS_COL_LSB +: COL_W] = cursor_column;
            rdata_nxt[`POS_ROW_LSB +: ROW_W] = cursor_row_r;
         end else if (s_axi_araddr == `STATUS_OFS) begin
            rdata_nxt[`STAT_CMATCH_LSB +: COL_W] = column_match_r[COL_W-1:0];
            rdata_nxt[`STAT_RMATCH_LSB +: ROW_W] = row_match_r;
            rdata_nxt[`STAT_TOP_BIT] = row_at_top_r;
            rdata_nxt[`STAT_BOTTOM_BIT] = row_at_bottom_r;
            rdata_nxt[`STAT_RHIT_BIT] = row_match_hit_r;
            rdata_nxt[`STAT_CHIT_N_BIT] = column_hit_n_r;
         end else if (s_axi_araddr == `CONTROL_OFS) begin
            rdata_nxt[`CTRL_KEY_EN_BIT] = key_enable_r;
         end else begin
            rresp_nxt = RESP_SLVERR;
         end
      end
      rvalid_nxt = (s_axi_arvalid & arready_r) | (rvalid_r & ~s_axi_rready);
      arready_nxt = ~rvalid_nxt;
   end

   // ---------------- Column match counter and preset path ----------------
   always_comb begin
      column_match_nxt = column_match_r;
      if (column_match_load) begin
         column_match_nxt = {1'h1, ~cursor_column}; // [R01] [R02] [R06] [R23]
      end else if (column_match_step & refresh_pass_en) begin // [R04] [R06]
         column_match_nxt = column_match_r + CM_ONE; // [R05]
      end
      column_hit_n_nxt = column_match_nxt[CM_W-1]; // [R02] [R05]
      // Preset lines carry the complement of the column being loaded
      column_preset_strobe_nxt = 1'h1;
      column_preset_n_nxt = column_preset_n_r;
      if (host_column_load) begin
         column_preset_n_nxt = ~host_column_bits; // [R08] [R10]
      end else if (restore_saved_cursor & phase_four_pulse) begin
         column_preset_n_nxt = column_match_r[COL_W-1:0]; // [R07] [R09] [R10]
      end else if (sw_col_wr) begin
         column_preset_n_nxt = ~wr_data[`POS_COL_LSB +: COL_W];
      end else begin
         column_preset_strobe_nxt = 1'h0;
      end
   end

   // ---------------- Row control and row up/down counter ----------------
   logic key_up_ok, key_down_ok, up_cmd, down_cmd, host_step, row_load;
   step_dir_t dir;
   always_comb begin
      key_up_ok = key_row_up & sequencer_slot_four & ~row_at_top_r & key_enable_r; // [R15] [R16]
      key_down_ok = key_row_down_return & sequencer_slot_four & ~row_at_bottom_r & key_enable_r; // [R15] [R16]
      up_cmd = row_previous | column_wrap_back | key_up_ok; // [R13] [R24]
      down_cmd = row_next | column_wrap_forward | key_down_ok; // [R13] [R24]
      host_step = host_row_next & host_step_pulse; // [R14]
      dir = (host_step | down_cmd) ? DIR_DOWN : DIR_UP; // [R14]
      cursor_step_pulse_nxt = host_step | (phase_three_pulse & (up_cmd | down_cmd)); // [R13] [R25]
      row_load = host_row_load | (line_delete_restore & phase_four_pulse); // [R17] [R18]
      row_counter_load_n_nxt = ~row_load; // [R17] [R18]
      cursor_row_nxt = cursor_row_r;
      if (host_row_load) begin
         cursor_row_nxt = host_row_bits;
      end else if (row_load) begin
         // Undo the match counter's complement to get the saved row back
         cursor_row_nxt = ~row_match_r; // [R07]
      end else if (sw_row_wr) begin
         cursor_row_nxt = wr_data[`POS_ROW_LSB +: ROW_W];
      end else if (cursor_step_pulse_nxt) begin
         case (dir)
            DIR_DOWN: cursor_row_nxt = cursor_row_r + ROW_ONE; // [R11] [R13]
            default: cursor_row_nxt = cursor_row_r - ROW_ONE; // [R11] [R13]
         endcase
      end
      row_at_top_nxt = (cursor_row_nxt == '0); // [R12]
      row_at_bottom_nxt = (cursor_row_nxt == ROW_END); // [R12]
   end

   // ---------------- Row match counter ----------------
   always_comb begin
      row_match_nxt = row_match_r;
      if (row_match_load) begin
         row_match_nxt = ~cursor_row_r; // [R19] [R20]
      end else if (row_gate_prev_r & ~row_match_gate) begin
         row_match_nxt = row_match_r + ROW_ONE; // [R21]
      end
      row_match_hit_nxt = &row_match_nxt; // [R22]
   end

   // ---------------- Registers ----------------
   // Single clock, synchronous active-low reset
   always_ff @(posedge clk) begin // [R25]
      if (!rst_b) begin
         column_match_r <= {1'h1, {COL_W{1'h0}}};
         column_hit_n_r <= 1'h1;
         column_preset_n_r <= '1;
         column_preset_strobe_r <= 1'h0;
         cursor_row_r <= '0;
         row_at_top_r <= 1'h1;
         row_at_bottom_r <= 1'h0;
         row_counter_load_n_r <= 1'h1;
         cursor_step_pulse_r <= 1'h0;
         row_match_r <= '0;
         row_match_hit_r <= 1'h0;
         row_gate_prev_r <= 1'h0;
         key_enable_r <= `CTRL_RESET;
         aw_held_r <= 1'h0;
         w_held_r <= 1'h0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         awready_r <= 1'h0;
         wready_r <= 1'h0;
         bvalid_r <= 1'h0;
         bresp_r <= RESP_OKAY;
         arready_r <= 1'h0;
         rvalid_r <= 1'h0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else begin
         column_match_r <= column_match_nxt;
         column_hit_n_r <= column_hit_n_nxt;
         column_preset_n_r <= column_preset_n_nxt;
         column_preset_strobe_r <= column_preset_strobe_nxt;
         cursor_row_r <= cursor_row_nxt;
         row_at_top_r <= row_at_top_nxt;
         row_at_bottom_r <= row_at_bottom_nxt;
         row_counter_load_n_r <= row_counter_load_n_nxt;
         cursor_step_pulse_r <= cursor_step_pulse_nxt;
         row_match_r <= row_match_nxt;
         row_match_hit_r <= row_match_hit_nxt;
         row_gate_prev_r <= row_match_gate;
         key_enable_r <= key_enable_nxt;
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign column_hit_n = column_hit_n_r;
   assign column_preset_n = column_preset_n_r;
   assign column_preset_strobe = column_preset_strobe_r;
   assign cursor_row = cursor_row_r;
   assign row_at_top = row_at_top_r;
   assign row_at_bottom = row_at_bottom_r;
   assign row_counter_load_n = row_counter_load_n_r;
   assign cursor_step_pulse = cursor_step_pulse_r;
   assign row_match_count = row_match_r;
   assign row_match_hit = row_match_hit_r;
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // ---------------- Assertions ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // A load followed by one unenabled cycle leaves the value held
   sequence s_col_loaded;
      column_match_load ##1 (!column_match_load && !refresh_pass_en);
   endsequence
   property p_col_load;
      column_match_load |=> (column_match_r == {1'h1, ~$past(cursor_column)}) && column_hit_n_r;
   endproperty
   a_col_load: assert property (p_col_load) else $error("column match load wrong"); // [R01] [R02]
   property p_col_hold;
      s_col_loaded |=> $stable(column_match_r);
   endproperty
   a_col_hold: assert property (p_col_hold) else $error("column match moved without enable"); // [R04] [R06]
   property p_col_step;
      (column_match_step && refresh_pass_en && !column_match_load)
         |=> column_match_r == $past(column_match_r) + CM_ONE;
   endproperty
   a_col_step: assert property (p_col_step) else $error("column step not counted"); // [R05]
   property p_host_col;
      host_column_load |=> column_preset_strobe_r && (column_preset_n_r == ~$past(host_column_bits));
   endproperty
   a_host_col: assert property (p_host_col) else $error("host column preset wrong"); // [R08] [R10]
   property p_restore_col;
      (restore_saved_cursor && phase_four_pulse && !host_column_load)
         |=> column_preset_n_r == $past(column_match_r[COL_W-1:0]);
   endproperty
   a_restore_col: assert property (p_restore_col) else $error("restored column wrong"); // [R07] [R09]
   property p_row_load;
      (host_row_load || (line_delete_restore && phase_four_pulse)) |=> !row_counter_load_n_r;
   endproperty
   a_row_load: assert property (p_row_load) else $error("row load output not low"); // [R17] [R18]
   property p_row_ends;
      (row_at_bottom_r == (cursor_row_r == ROW_END)) && (row_at_top_r == (cursor_row_r == '0));
   endproperty
   a_row_ends: assert property (p_row_ends) else $error("row end flags wrong"); // [R12]
   property p_key_guard;
      (key_row_down_return && row_at_bottom_r && !row_next && !row_previous && !column_wrap_forward
         && !column_wrap_back && !host_step && !row_load && !sw_row_wr && !key_row_up) |=> $stable(cursor_row_r);
   endproperty
   a_key_guard: assert property (p_key_guard) else $error("keyboard down moved past bottom"); // [R16]
   property p_row_next;
      (phase_three_pulse && row_next && !row_load && !sw_row_wr) |=> cursor_row_r == $past(cursor_row_r) + ROW_ONE;
   endproperty
   a_row_next: assert property (p_row_next) else $error("row next not counted"); // [R13]
   property p_row_match;
      row_match_load |=> row_match_r == ~$past(cursor_row_r);
   endproperty
   a_row_match: assert property (p_row_match) else $error("row match load wrong"); // [R19] [R20]
   property p_row_gate;
      ($fell(row_match_gate) && !row_match_load) |=> row_match_r == $past(row_match_r) + ROW_ONE;
   endproperty
   a_row_gate: assert property (p_row_gate) else $error("row match not advanced"); // [R21]

endmodule : cursor_position_match

// ==== verif/refresh_side_model.sv ====
// Far-side model of the refresh logic: a sweep load followed by column steps.
// Assumes one clk domain; go is a one-cycle request while busy is low.
`timescale 1ns/100ps
module refresh_side_model (
   input wire logic clk,
   input wire logic go,
   input wire logic [3:0] n_steps,
   output logic column_match_load,
   output logic column_match_step,
   output logic busy
);
   logic [4:0] cnt_r = 5'h00;
   initial begin
      column_match_load = 1'b0;
      column_match_step = 1'b0;
      busy = 1'b0;
   end
   // Load at sweep start, then one step pulse every other cycle, never back to back
   always @(posedge clk) begin
      column_match_load <= go && !busy;
      column_match_step <= busy && cnt_r[0];
      if (go && !busy) begin
         busy <= 1'b1;
         cnt_r <= {n_steps, 1'b0};
      end else if (cnt_r != 5'h00) begin
         cnt_r <= cnt_r - 5'h01;
      end else begin
         busy <= 1'b0;
      end
   end
endmodule : refresh_side_model

// ==== verif/test_cursor_position_match.sv ====
// Self-checking bench for the cursor position match block.
// Assumes the package and defs header compile first and the refresh side model.
`timescale 1ns/100ps
`include "cursor_position_match_defs.svh"
module test_cursor_position_match
   import cursor_position_match_pkg::*;
;
   logic clk = 1'b0, rst_b = 1'b0, go = 1'b0, en = 1'b1, rml = 1'b0, rmg = 1'b0, ldr = 1'b0;
   logic p3 = 1'b0, p4 = 1'b0, rsc = 1'b0, hcl = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic [3:0] nst = 4'h0, awa = 4'h0, ara = 4'h0, ws = 4'h0;
   logic [4:0] hrb = 5'h00, prev, row, rmc;
   logic [6:0] hcb = 7'h00, pre_n, col = 7'h04;
   logic [8:0] cmd = 9'h000;
   logic [31:0] wd = 32'h0, rd;
   logic [1:0] bresp, rresp;
   logic [33:0] q;
   logic cml, cms, busy, awr, wr, bv, arr, rv, hit_n, strb, top, bot, rload_n, stp, rhit;
   int n_errors = 0, check_count = 0;
   // Row cases: {commands, host row bits, expected row}
   logic [18:0] tbl [13] = '{{9'h001, 5'h19, 5'h19}, {9'h002, 5'h00, 5'h1A}, {9'h108, 5'h00, 5'h1A},
      {9'h110, 5'h00, 5'h19}, {9'h010, 5'h00, 5'h19}, {9'h004, 5'h00, 5'h18}, {9'h001, 5'h00, 5'h00},
      {9'h110, 5'h00, 5'h00}, {9'h020, 5'h00, 5'h01}, {9'h040, 5'h00, 5'h00}, {9'h080, 5'h00, 5'h01},
      {9'h108, 5'h00, 5'h02}, {9'h001, 5'h00, 5'h00}};

   refresh_side_model model_u (.clk(clk), .go(go), .n_steps(nst), .column_match_load(cml),
      .column_match_step(cms), .busy(busy));
   cursor_position_match dut_u (.clk(clk), .rst_b(rst_b), .cursor_column(col), .column_match_load(cml),
      .column_match_step(cms), .refresh_pass_en(en), .restore_saved_cursor(rsc), .phase_four_pulse(p4),
      .phase_three_pulse(p3), .host_column_load(hcl), .host_column_bits(hcb), .column_wrap_forward(cmd[5]),
      .column_wrap_back(cmd[6]), .row_next(cmd[1]), .row_previous(cmd[2]), .host_row_next(cmd[7]),
      .host_step_pulse(cmd[7]), .key_row_up(cmd[4]), .key_row_down_return(cmd[3]), .sequencer_slot_four(cmd[8]),
      .host_row_load(cmd[0]), .host_row_bits(hrb), .line_delete_restore(ldr), .row_match_load(rml),
      .row_match_gate(rmg), .column_hit_n(hit_n), .column_preset_n(pre_n), .column_preset_strobe(strb),
      .cursor_row(row), .row_at_top(top), .row_at_bottom(bot), .row_counter_load_n(rload_n),
      .cursor_step_pulse(stp), .row_match_count(rmc), .row_match_hit(rhit), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rre));

   // 25 MHz clock
   initial begin
      forever #20 clk = ~clk;
   end

   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize

   task automatic tmo;
      n_errors++;
      summarize();
   endtask : tmo

   task automatic chk(input logic [39:0] g, input logic [39:0] e);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask : chk

   // Bus write: address and data offered together, each released once taken
   task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
      int k;
      k = 0;
      awa <= a;
      wd <= d;
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      do begin
         @(posedge clk);
         k++;
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while (!bv && k < 50);
      bre <= 1'b0;
      if (k >= 50) tmo();
      chk(bresp, e);
   endtask : axw

   // Bus read: returns {response, data}
   task automatic axr(input logic [3:0] a, output logic [33:0] r);
      int k;
      k = 0;
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do begin
         @(posedge clk);
         k++;
         if (arr) arv <= 1'b0;
      end while (!rv && k < 50);
      r = {rresp, rd};
      rre <= 1'b0;
      if (k >= 50) tmo();
   endtask : axr

   // One refresh sweep: load, n steps, then column hit and saved count
   task automatic col_run(input logic e, input logic [3:0] n, input logic [7:0] x);
      int k;
      en <= e;
      nst <= n;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (busy && k < 50);
      if (k >= 50) tmo();
      @(posedge clk);
      chk(hit_n, x[7]);
      axr(`STATUS_OFS, q);
      chk({q[19], q[6:0]}, x);
   endtask : col_run

   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk({hit_n, pre_n, top, rload_n, row, rmc}, {1'b1, 7'h7F, 1'b1, 1'b1, 5'h00, 5'h00});
      $display("reset test done");
      col_run(1'b1, 4'h4, 8'hFF);
      col_run(1'b1, 4'h5, 8'h00);
      col_run(1'b0, 4'h5, 8'hFB);
      rsc <= 1'b1;
      p4 <= 1'b1;
      @(posedge clk);
      rsc <= 1'b0;
      p4 <= 1'b0;
      @(posedge clk);
      chk({strb, pre_n}, 8'hFB);
      hcl <= 1'b1;
      hcb <= 7'h15;
      @(posedge clk);
      hcl <= 1'b0;
      @(posedge clk);
      chk({strb, pre_n}, 8'hEA);
      col <= 7'h02;
      col_run(1'b1, 4'h3, 8'h00);
      $display("column test done");
      for (int i = 0; i < 13; i++) begin
         prev = row;
         cmd <= tbl[i][18:10];
         hrb <= tbl[i][9:5];
         p3 <= 1'b1;
         @(posedge clk);
         cmd <= 9'h000;
         p3 <= 1'b0;
         @(posedge clk);
         chk(rload_n, !tbl[i][10]);
         chk(stp, !tbl[i][10] && tbl[i][4:0] != prev);
         repeat (2) @(posedge clk);
         chk(row, tbl[i][4:0]);
         chk({top, bot}, {tbl[i][4:0] == 5'h00, tbl[i][4:0] == 5'h1A});
      end
      $display("row test done");
      rml <= 1'b1;
      @(posedge clk);
      rml <= 1'b0;
      @(posedge clk);
      chk({rhit, rmc}, 6'h3F);
      rmg <= 1'b1;
      @(posedge clk);
      rmg <= 1'b0;
      repeat (3) @(posedge clk);
      chk({rhit, rmc}, 6'h00);
      ldr <= 1'b1;
      p4 <= 1'b1;
      @(posedge clk);
      ldr <= 1'b0;
      p4 <= 1'b0;
      @(posedge clk);
      chk(rload_n, 1'b0);
      repeat (2) @(posedge clk);
      chk(row, 5'h1F);
      $display("row match test done");
      axr(`CONTROL_OFS, q);
      chk(q, {RESP_OKAY, 32'h1});
      axw(`CONTROL_OFS, 32'h0, 4'h1, RESP_OKAY);
      axr(`CONTROL_OFS, q);
      chk(q, {RESP_OKAY, 32'h0});
      axw(`POSITION_OFS, 32'h0A2B, 4'h3, RESP_OKAY);
      chk({row, pre_n}, {5'h0A, 7'h54});
      axr(`POSITION_OFS, q);
      chk(q, {RESP_OKAY, 32'h0A02});
      axw(4'hC, 32'h0, 4'hF, RESP_SLVERR);
      axr(4'hC, q);
      chk(q[33:32], RESP_SLVERR);
      $display("bus test done");
      summarize();
   end
endmodule : test_cursor_position_match
